// ### hw/bfm_monitor.sv
// bridge driver fault monitor with apb register slave
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module bfm_monitor #(
   parameter int timeout_cycles = bfm_pkg::enable_timeout_cycles // enable watchdog timeout
) (
   input wire logic pclk, // apb clock, 200 mhz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data, registered
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic regulator_uv, // regulator below threshold
   input wire logic regulator_ov, // regulator above threshold
   input wire logic supply_ov, // main supply above threshold
   input wire logic supply_uv, // main supply below threshold
   input wire logic [3:0] gate_uv, // per gate low vgs: a high, a low, b high, b low
   input wire logic [5:0] input_pin_ov, // overvoltage on the six input terminals
   input wire logic fault_pin_ov, // overvoltage on the fault output terminal
   input wire logic enable_in, // enable input level
   input wire logic phase_a_high_input, // phase a high side command
   input wire logic phase_a_low_input_n, // phase a low side command, active low
   input wire logic phase_b_high_input_n, // phase b high side command, active low
   input wire logic phase_b_low_input, // phase b low side command
   input wire logic [1:0] oc_compare, // overcurrent comparators, phase a, b
   output logic [3:0] gate_drive, // gate commands: a high, a low, b high, b low
   output logic fault_flag, // general fault flag, active high
   output logic [3:0] overcurrent_level_code, // threshold code to analog dac
   output logic [3:0] amplifier_offset_code, // offset code to sense amplifier
   output logic bridge_on_state, // one diagonal pair on
   output logic bridge_off_state // all gates off
);
   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   localparam int sync_w = 18; // width of synchronised input group
   logic [sync_w-1:0] sync_a; // first stage, read only by sync_b
   logic [sync_w-1:0] sync_b; // second stage

   logic [sync_w-1:0] raw_in; // gathered inputs
   assign raw_in = {oc_compare, enable_in, fault_pin_ov, input_pin_ov, gate_uv,
                    supply_uv, supply_ov, regulator_ov, regulator_uv};

   // two flops per input ahead of all fault logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic s_reg_uv, s_reg_ov, s_sup_ov;
   logic s_sup_uv, s_fault_ov, s_enable;
   logic [3:0] s_gate_uv; // synchronised gate low flags
   logic [5:0] s_in_ov; // synchronised input pin flags
   logic [1:0] s_oc; // synchronised comparators

   assign s_reg_uv = sync_b[0];
   assign s_reg_ov = sync_b[1];
   assign s_sup_ov = sync_b[2];
   assign s_sup_uv = sync_b[3];
   assign s_gate_uv = sync_b[7:4];
   assign s_in_ov = sync_b[13:8];
   assign s_fault_ov = sync_b[14];
   assign s_enable = sync_b[15];
   assign s_oc = sync_b[17:16];

   // ---------------------------------------------
   // apb slave and configuration
   // ---------------------------------------------
   localparam int fault_w = bfm_pkg::fault_bits;
   logic [15:0] config_reg; // control settings
   logic [fault_w-1:0] status; // latched fault bits
   logic stop_on_fault_select, watchdog_select_bit;
   logic qualifier_mode_select;
   logic [3:0] qualifier_time_code; // qualifier period in 500 ns steps
   logic wr_en, rd_en, addr_ok; // decoded strobes

   logic [fault_w-1:0] clear_mask; // bits cleared this cycle

   logic [fault_w-1:0] live; // live fault conditions

   assign stop_on_fault_select = config_reg[bfm_pkg::cfg_stop_on_fault];
   assign watchdog_select_bit = config_reg[bfm_pkg::cfg_watchdog];
   assign qualifier_mode_select = config_reg[bfm_pkg::cfg_qual_mode];
   assign overcurrent_level_code = config_reg[bfm_pkg::cfg_oc_level_lo +: 4];
   assign qualifier_time_code = config_reg[bfm_pkg::cfg_qual_time_lo +: 4];
   assign amplifier_offset_code = config_reg[bfm_pkg::cfg_amp_off_lo +: 4];

   assign pready = 1'b1; // zero wait states

   assign addr_ok = (paddr == bfm_pkg::addr_config) || (paddr == bfm_pkg::addr_status) ||
                    (paddr == bfm_pkg::addr_clear) || (paddr == bfm_pkg::addr_live);
   assign pslverr = psel && penable && !addr_ok; // unmapped answers with error

   assign wr_en = psel && penable && pwrite && addr_ok;
   // read data taken in setup, one edge early
   assign rd_en = psel && !penable && !pwrite;

   assign clear_mask = (wr_en && paddr == bfm_pkg::addr_clear) ?
                       pwdata[fault_w-1:0] : '0;

   // configuration register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= bfm_pkg::cfg_reset;
      end else if (wr_en && paddr == bfm_pkg::addr_config) begin
         config_reg <= pwdata[15:0];
      end
   end

   // read data captured in setup so it is stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         case (paddr)
            bfm_pkg::addr_config: prdata <= {16'h0000, config_reg};
            bfm_pkg::addr_status: prdata <= {16'h0000, |status, 3'h0, status};
            bfm_pkg::addr_live: prdata <= {20'h00000, live};
            default: prdata <= '0; // clear register and unmapped read zero
         endcase
      end
   end

   // ---------------------------------------------
   // enable watchdog
   // ---------------------------------------------
   bfm_pkg::bfm_wd_t wd_state; // watchdog state
   logic [31:0] wd_count; // cycles since last enable edge

   logic enable_prev; // enable level a cycle ago
   logic enable_edge; // any change of enable
   logic wd_allow; // watchdog lets gates follow phases

   assign enable_edge = s_enable ^ enable_prev;

   // edge detection on the synchronised enable only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // idle watchdog ignores the false edge
         enable_prev <= 1'b0;
      end else begin
         enable_prev <= s_enable;
      end
   end

   // watchdog sequence; leaving watchdog mode restarts at first edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_state <= bfm_pkg::bfm_wd_wait_first;
         wd_count <= '0;
      end else if (!watchdog_select_bit) begin
         wd_state <= bfm_pkg::bfm_wd_wait_first;
         wd_count <= '0;
      end else begin
         case (wd_state)
            bfm_pkg::bfm_wd_wait_first: begin
               if (enable_edge) begin
                  wd_state <= bfm_pkg::bfm_wd_run;
                  wd_count <= '0;
               end
            end
            bfm_pkg::bfm_wd_run: begin
               if (enable_edge) begin
                  wd_count <= '0;
               end else if (wd_count >= 32'(timeout_cycles - 1)) begin
                  wd_state <= bfm_pkg::bfm_wd_timed_out;
               end else begin
                  wd_count <= wd_count + 32'h00000001;
               end
            end
            bfm_pkg::bfm_wd_timed_out: begin
               // gates off until a new edge
               if (enable_edge) begin
                  wd_state <= bfm_pkg::bfm_wd_run;
                  wd_count <= '0;
               end
            end
            default: wd_state <= bfm_pkg::bfm_wd_wait_first;
         endcase
      end
   end
   // direct mode follows the enable level; watchdog mode ignores it
   assign wd_allow = watchdog_select_bit ? (wd_state == bfm_pkg::bfm_wd_run) :
                     s_enable;

   // ---------------------------------------------
   // gate drive decode
   // ---------------------------------------------
   logic [3:0] phase_cmd; // requested gates
   logic inhibit; // gates forced off
   logic in_pin_stop; // input pin overvoltage stop

   // active-low pins are inverted here
   assign phase_cmd = {phase_b_low_input, !phase_b_high_input_n,
                       !phase_a_low_input_n, phase_a_high_input};
   assign in_pin_stop = stop_on_fault_select && (|s_in_ov); // fault pin alone never stops

   // overcurrent does not appear here on purpose
   assign inhibit = s_sup_uv || in_pin_stop || !wd_allow;

   // registered gate outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_drive <= 4'h0;
      end else begin
         gate_drive <= inhibit ? 4'h0 : phase_cmd;
      end
   end

   // on-state: a high with b low, or b high with a low
   assign bridge_on_state = (gate_drive == 4'h9) ||
                            (gate_drive == 4'h6);
   assign bridge_off_state = (gate_drive == 4'h0);

   // ---------------------------------------------
   // overcurrent qualifier, one per phase
   // ---------------------------------------------
   logic [1:0] oc_valid; // qualified overcurrent events

   logic [3:0] gate_prev; // gate drive a cycle ago
   // last gates give the low-side turn-on edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_prev <= 4'h0;
      end else begin
         gate_prev <= gate_drive;
      end
   end

   localparam int step_w = 8; // width of step prescaler

   localparam logic [step_w-1:0] step_last = step_w'(bfm_pkg::qual_step_cycles - 1);

   // phase a first, then b
   genvar ph;
   generate
      for (ph = 0; ph < 2; ph++) begin : g_qual
         logic low_on; // low side of this phase driven
         logic low_rise; // low side just turned on

         logic [step_w-1:0] pre; // cycles within one 500 ns step
         logic [3:0] steps; // whole steps counted
         logic running; // timer active
         logic expired; // period complete

         assign low_on = gate_drive[2*ph+1];
         assign low_rise = low_on && !gate_prev[2*ph+1];

         assign expired = running && (steps >= qualifier_time_code);

         // timer: debounce runs while comparator high, blanking after low turn-on
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               running <= 1'b0;
               pre <= '0;
               steps <= 4'h0;
            end else if (!qualifier_mode_select ? !(s_oc[ph] && low_on) : low_rise) begin
               running <= !qualifier_mode_select ? 1'b0 : 1'b1;
               pre <= '0;
               steps <= 4'h0;
            end else if (!running) begin
               running <= !qualifier_mode_select; // debounce start
            end else if (expired) begin
               running <= !qualifier_mode_select; // blanking ends, debounce holds
            end else if (pre == step_last) begin
               pre <= '0;
               steps <= steps + 4'h1;
            end else begin
               pre <= pre + step_w'(1);
            end
         end
         // debounce: comparator held for full period; blanking: any report outside window
         assign oc_valid[ph] = !qualifier_mode_select ? expired : (s_oc[ph] && !running);
      end
   endgenerate

   // ---------------------------------------------
   // fault latching and flag
   // ---------------------------------------------
   logic pin_ov_any; // any of seven terminals high
   assign pin_ov_any = (|s_in_ov) || s_fault_ov;

   assign live = {oc_valid, wd_state == bfm_pkg::bfm_wd_timed_out, pin_ov_any,
                  s_gate_uv & gate_drive, s_sup_uv, s_sup_ov, s_reg_ov, s_reg_uv};

   // sticky bits; a new event in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         // clear first, then set, so set wins
         status <= (status & ~clear_mask) | live;
      end
   end

   // flag follows live conditions and active disables, not latched history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_flag <= 1'b0;
      end else begin
         // overcurrent stays out of the flag
         fault_flag <= (|live[9:0]) || in_pin_stop;
      end
   end
endmodule

// ### hw/bfm_pkg.sv
// package of constants and types for the bridge driver fault monitor
package bfm_pkg;
   // ---------------------------------------------
   // register map (byte addresses on apb)
   // ---------------------------------------------
   localparam logic [7:0] addr_config = 8'h00; // control settings
   localparam logic [7:0] addr_status = 8'h04; // latched fault bits
   localparam logic [7:0] addr_clear = 8'h08; // write ones to clear status bits
   localparam logic [7:0] addr_live = 8'h0c; // live conditions, read only

   // ---------------------------------------------
   // config field positions
   // ---------------------------------------------
   localparam int cfg_stop_on_fault = 0; // stop_on_fault_select
   localparam int cfg_watchdog = 1; // watchdog_select_bit
   localparam int cfg_qual_mode = 2; // qualifier_mode_select, 1 = blanking
   localparam int cfg_oc_level_lo = 4; // overcurrent_level_code [7:4]
   localparam int cfg_qual_time_lo = 8; // qualifier_time_code [11:8]
   localparam int cfg_amp_off_lo = 12; // amplifier_offset_code [15:12]
   localparam logic [15:0] cfg_reset = 16'h0000; // debounce, direct enable, no stop

   // ---------------------------------------------
   // status field positions
   // ---------------------------------------------
   localparam int st_regulator_low = 0;
   localparam int st_regulator_high = 1;
   localparam int st_supply_high = 2;
   localparam int st_supply_low = 3;
   localparam int st_gate_low_lo = 4; // four gate bits [7:4]: a high, a low, b high, b low
   localparam int st_logic_pin_ov = 8;
   localparam int st_enable_timeout = 9;
   localparam int st_oc_a = 10;
   localparam int st_oc_b = 11;
   localparam int st_summary = 15; // any_fault_summary_bit
   localparam int fault_bits = 12; // bits 11:0 hold faults

   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int clk_period_ps = 5000; // 200 mhz
   localparam int qual_step_ns = 500; // one qualifier time code step
   localparam int qual_step_cycles = (qual_step_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
   localparam int enable_timeout_us = 1000; // arbitrary default timeout
   localparam int enable_timeout_cycles = enable_timeout_us * 1000000 / clk_period_ps;

   // enable watchdog states
   typedef enum logic [1:0] {bfm_wd_wait_first, bfm_wd_run, bfm_wd_timed_out} bfm_wd_t;
endpackage

// ### testbench/bfm_ctrl_model.sv
// external controller model: drives the enable and phase command pins
`timescale 1ns/1ps
module bfm_ctrl_model (
   input wire logic pclk, // device clock
   input wire logic presetn, // async reset, active low
   input wire logic run, // keep toggling enable
   input wire logic [7:0] gap, // idle cycles between enable edges
   input wire logic [3:0] want, // wanted gates: a high, a low, b high, b low
   output logic enable_in, // enable level
   output logic phase_a_high_input, // phase a high command
   output logic phase_a_low_input_n, // phase a low command, active low
   output logic phase_b_high_input_n, // phase b high command, active low
   output logic phase_b_low_input // phase b low command
);
   // -----------------------------
   // enable toggling
   // -----------------------------
   logic [7:0] count; // cycles since the last enable edge
   // when stopped the pin returns high, so direct mode always sees enable on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
         enable_in <= 1'b1;
      end else if (!run) begin
         count <= 8'h00;
         enable_in <= 1'b1;
      end else if (count >= gap) begin // toggle well inside the timeout
         count <= 8'h00;
         enable_in <= !enable_in;
      end else begin
         count <= count + 8'h01;
      end
   end
   // phase pins follow the wanted gates, with each pin's own polarity
   assign phase_a_high_input = want[0];
   assign phase_a_low_input_n = !want[1];
   assign phase_b_high_input_n = !want[2];
   assign phase_b_low_input = want[3];
endmodule

// ### testbench/bfm_monitor_sva.sv
// port checker for the bridge driver fault monitor
`timescale 1ns/1ps
module bfm_monitor_sva #(
   parameter int timeout_cycles = 50 // watchdog count, handed on
) (
   input wire logic pclk, // device clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic regulator_uv, // regulator low
   input wire logic regulator_ov, // regulator high
   input wire logic supply_ov, // supply high
   input wire logic supply_uv, // supply low
   input wire logic [5:0] input_pin_ov, // input pin overvoltage
   input wire logic fault_pin_ov, // fault pin overvoltage
   input wire logic phase_a_high_input, // phase a high command
   input wire logic [3:0] gate_drive, // gate commands
   input wire logic fault_flag, // general fault flag
   input wire logic [3:0] overcurrent_level_code, // threshold code
   input wire logic bridge_on_state, // diagonal pair on
   input wire logic bridge_off_state // all gates off
);
   // -----------------------------
   // helper terms
   // -----------------------------
   logic any_live; // a monitor that must raise the flag
   logic cfg_wr; // config write taking effect
   assign any_live = regulator_uv | regulator_ov | supply_ov | supply_uv | (|input_pin_ov) | fault_pin_ov;
   assign cfg_wr = psel & penable & pwrite & (paddr == bfm_pkg::addr_config);
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // five samples cover both sync stages and the output register
   sequence supply_low_held_s;
      supply_uv [*5];
   endsequence
   sequence live_held_s;
      any_live [*5];
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   // -----------------------------
   // assertions
   // -----------------------------
   apb_ready_a: assert property (access_s |-> pready)
      else $error("pready low in access phase");
   apb_decode_a: assert property (access_s |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
      else $error("pslverr does not match the address map");
   supply_off_a: assert property (supply_low_held_s |-> gate_drive == 4'h0)
      else $error("gates driven during supply low");
   flag_raise_a: assert property (live_held_s |-> fault_flag)
      else $error("fault flag low while a monitor is active");
   off_decode_a: assert property (bridge_off_state == (gate_drive == 4'h0))
      else $error("off state decode wrong");
   on_decode_a: assert property (bridge_on_state == (gate_drive == 4'h9 || gate_drive == 4'h6))
      else $error("on state decode wrong");
   phase_follow_a: assert property (!phase_a_high_input [*5] |-> !gate_drive[0])
      else $error("phase a high gate on without command");
   level_code_a: assert property ($changed(overcurrent_level_code) |-> $past(cfg_wr))
      else $error("level code changed without a config write");
endmodule
bind bfm_monitor bfm_monitor_sva #(.timeout_cycles(timeout_cycles)) bfm_monitor_sva_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .regulator_uv(regulator_uv), .regulator_ov(regulator_ov), .supply_ov(supply_ov),
   .supply_uv(supply_uv), .input_pin_ov(input_pin_ov), .fault_pin_ov(fault_pin_ov),
   .phase_a_high_input(phase_a_high_input), .gate_drive(gate_drive), .fault_flag(fault_flag),
   .overcurrent_level_code(overcurrent_level_code), .bridge_on_state(bridge_on_state),
   .bridge_off_state(bridge_off_state));

// ### testbench/tb_top.sv
// self-checking testbench for the bridge driver fault monitor
`timescale 1ns/1ps
module tb_top;
   // -----------------------------
   // signals
   // -----------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // clock, reset, apb
   logic [7:0] paddr; // apb address
   logic [31:0] pwdata, prdata, rd_q; // apb data, read data before the edge
   logic [3:0] live, gate_uv, want, gd, ocl, aoc, gd_q; // stimulus and gate results
   logic [6:0] pins; // six input pins, then the fault pin
   logic [1:0] oc_compare; // overcurrent comparators
   logic [7:0] gap; // controller edge spacing
   logic run, en, pa_h, pa_ln, pb_hn, pb_l, ff, on_st, off_st; // controller pins, flags
   logic rdy_q, err_q, err_l, ff_q, on_q, off_q; // values held just before each edge
   int fail_count, samples_checked;
   localparam logic [3:0] pat = 4'h9; // a high with b low
   bfm_monitor #(.timeout_cycles(50)) bfm_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .regulator_uv(live[0]), .regulator_ov(live[1]), .supply_ov(live[2]),
      .supply_uv(live[3]), .gate_uv(gate_uv), .input_pin_ov(pins[5:0]), .fault_pin_ov(pins[6]),
      .enable_in(en), .phase_a_high_input(pa_h), .phase_a_low_input_n(pa_ln), .phase_b_high_input_n(pb_hn),
      .phase_b_low_input(pb_l), .oc_compare(oc_compare), .gate_drive(gd), .fault_flag(ff),
      .overcurrent_level_code(ocl), .amplifier_offset_code(aoc), .bridge_on_state(on_st),
      .bridge_off_state(off_st));
   bfm_ctrl_model bfm_ctrl_model_i (.pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .want(want),
      .enable_in(en), .phase_a_high_input(pa_h), .phase_a_low_input_n(pa_ln),
      .phase_b_high_input_n(pb_hn), .phase_b_low_input(pb_l));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // outputs only move at rising edges, so the falling edge holds settled values
   always @(negedge pclk) begin
      {rd_q, rdy_q, err_q} = {prdata, pready, pslverr};
      {gd_q, ff_q, on_q, off_q} = {gd, ff, on_st, off_st};
   end
   // -----------------------------
   // shared tasks
   // -----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // setup cycle, then access until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rdy_q !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         tally_and_finish();
      end
      {q, err_l} = {rd_q, err_q};
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_regs;
      logic [31:0] q;
      rd_chk(bfm_pkg::addr_config, 32'h0);
      wr(bfm_pkg::addr_status, 32'hffff); // read-only place, must stay clear
      rd_chk(bfm_pkg::addr_status, 32'h0);
      apb(1'b0, 8'h10, 32'h0, q);
      chk(err_l, 1'b1);
      chk(q, 32'h0);
      cyc(8);
      chk({on_q, off_q, gd_q}, {2'b01, 4'h0});
      want <= pat;
      cyc(8);
      chk({on_q, off_q, gd_q}, {2'b10, pat});
      $display("test registers and decode done");
   endtask
   task automatic t_live; // one monitor at a time; only supply low stops the gates
      for (int k = 0; k < 4; k++) begin
         live <= 4'h1 << k;
         cyc(8);
         chk({ff_q, gd_q}, {1'b1, k == 3 ? 4'h0 : pat});
         live <= 4'h0;
         cyc(8);
         chk({ff_q, gd_q}, {1'b0, pat});
         rd_chk(bfm_pkg::addr_status, 32'h8000 | (32'h1 << k));
         wr(bfm_pkg::addr_clear, 32'hfff);
         rd_chk(bfm_pkg::addr_status, 32'h0);
      end
      $display("test supply monitors done");
   endtask
   task automatic t_pins; // every pin, with stop on fault off and then on
      for (int s = 0; s < 2; s++) begin
         wr(bfm_pkg::addr_config, s ? 32'h1 : 32'h0);
         for (int k = 0; k < 7; k++) begin
            pins <= 7'h1 << k;
            cyc(8);
            chk({ff_q, gd_q}, {1'b1, (s == 1 && k < 6) ? 4'h0 : pat});
            pins <= 7'h0;
            cyc(8);
            chk({ff_q, gd_q}, {1'b0, pat});
            rd_chk(bfm_pkg::addr_status, 32'h8100);
            wr(bfm_pkg::addr_clear, 32'hfff);
         end
      end
      $display("test pin overvoltage done");
   endtask
   task automatic t_gates; // each gate low voltage while that gate is driven
      logic [3:0] w;
      for (int k = 0; k < 4; k++) begin
         w = (k == 0 || k == 3) ? 4'h9 : 4'h6;
         want <= w;
         cyc(8);
         gate_uv <= 4'h1 << k;
         cyc(8);
         chk({ff_q, gd_q}, {1'b1, w});
         gate_uv <= 4'h0;
         cyc(8);
         chk(ff_q, 1'b0);
         rd_chk(bfm_pkg::addr_status, 32'h8000 | (32'h10 << k));
         wr(bfm_pkg::addr_clear, 32'hfff);
      end
      want <= pat;
      $display("test gate low voltage done");
   endtask
   task automatic t_watchdog; // first edge, steady toggling, stall, recovery
      wr(bfm_pkg::addr_config, 32'h2);
      cyc(8);
      chk(gd_q, 4'h0);
      run <= 1'b1;
      cyc(40);
      chk({ff_q, gd_q}, {1'b0, pat});
      run <= 1'b0;
      cyc(80);
      chk({ff_q, gd_q}, {1'b1, 4'h0});
      run <= 1'b1;
      cyc(20);
      chk({ff_q, gd_q}, {1'b0, pat});
      rd_chk(bfm_pkg::addr_status, 32'h8200);
      run <= 1'b0;
      wr(bfm_pkg::addr_config, 32'h0);
      wr(bfm_pkg::addr_clear, 32'hfff);
      $display("test enable watchdog done");
   endtask
   // time code 2 gives 200 cycles; a short late pulse only counts when blanking
   task automatic t_qual;
      logic [3:0] w;
      for (int m = 0; m < 2; m++) begin
         wr(bfm_pkg::addr_config, m ? 32'h52a4 : 32'h52a0);
         cyc(1);
         chk({aoc, ocl}, 8'h5a);
         for (int p = 0; p < 2; p++) begin
            w = p ? 4'h9 : 4'h6;
            want <= 4'h0;
            cyc(8);
            want <= w;
            cyc(4);
            oc_compare <= 2'h1 << p;
            cyc(150);
            oc_compare <= 2'h0;
            rd_chk(bfm_pkg::addr_status, 32'h0);
            cyc(100);
            oc_compare <= 2'h1 << p;
            cyc(60);
            oc_compare <= 2'h0;
            rd_chk(bfm_pkg::addr_status, m ? 32'h8000 | (32'h400 << p) : 32'h0);
            oc_compare <= 2'h1 << p;
            cyc(250);
            chk({ff_q, gd_q}, {1'b0, w});
            oc_compare <= 2'h0;
            rd_chk(bfm_pkg::addr_status, 32'h8000 | (32'h400 << p));
            wr(bfm_pkg::addr_clear, 32'hfff);
         end
      end
      $display("test overcurrent qualifier done");
   endtask
   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {live, gate_uv, pins, oc_compare, run, want, gap} = {4'h0, 4'h0, 7'h00, 2'h0, 1'b0, 4'h0, 8'h0a};
      fail_count = 0;
      samples_checked = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_live();
      t_pins();
      t_gates();
      t_watchdog();
      t_qual();
      tally_and_finish();
   end
endmodule
